// File: rtl/ccrc_pkg.sv
// Constants, register map and carrier types of the CRC engine.
// Assumes one 250 MHz clock and an APB register port with 32-bit data.
package ccrc_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_LEN = 8'h04;
	localparam logic [7:0] OFF_DAT_LO = 8'h08;
	localparam logic [7:0] OFF_DAT_HI = 8'h0C;
	localparam logic [7:0] OFF_ACC = 8'h10;
	localparam logic [7:0] OFF_TAPS = 8'h14;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_AUG_BIT = 1;
	localparam int CTRL_ORDER_BIT = 2;
	localparam int CTRL_BUSY_BIT = 4;
	localparam int CTRL_FULL_BIT = 5;
	localparam int LEN_DATA_LENGTH_FIELD_LSB = 0;
	localparam int LEN_POLY_LENGTH_FIELD_LSB = 4;
	localparam int FIELD_W = 4;
	localparam int CRC_W = 16;
	localparam int BYTE_W = 8;
	localparam int IRQ_W = 2;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_OVR_BIT = 1;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_ACC = 16'h0000;
	localparam logic [15:0] RST_TAPS = 16'h0000;
	localparam logic [7:0] RST_DATA_HI = 8'h00;
	localparam logic [15:0] RST_STAGE = 16'h0000;
	localparam logic [3:0] RST_LEN_FIELD = 4'h0;
	localparam logic [1:0] RST_IRQ_MASK = 2'h0;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic go;
		logic augment;
		logic lsb_first;
		logic [3:0] data_len;
		logic [3:0] poly_len;
	} ccrc_cfg_t;

	typedef enum logic [0:0] {
		ST_EMPTY = 1'b0,
		ST_FULL = 1'b1
	} ccrc_state_t;

endpackage

// File: rtl/ccrc_bit_step.sv
// One shift of the CRC remainder register by one data bit.
// Assumes taps arrive with the lowest term already forced to one.
`timescale 1ns/100ps
module ccrc_bit_step
	import ccrc_pkg::*;
(
	input wire logic [15:0] acc,
	input wire logic [15:0] taps,
	input wire logic [3:0] poly_len,
	input wire logic augment,
	input wire logic din,
	output logic [15:0] next_acc
);
	logic [4:0] width;
	logic [15:0] mask;
	logic msb;
	logic fb;
	logic [15:0] shifted;

	// Width mask; a shift by 16 empties the ones, giving a full mask
	assign width = {1'b0, poly_len} + 5'd1;
	assign mask = ~(16'hFFFF << width);
	assign msb = acc[poly_len];
	// Augmented form feeds data at the top, equal to trailing zeros
	assign fb = augment ? (msb ^ din) : msb;
	assign shifted = augment ? {acc[14:0], 1'b0} : {acc[14:0], din};
	assign next_acc = (shifted ^ (fb ? taps : 16'h0000)) & mask;
endmodule // ccrc_bit_step

// File: rtl/ccrc_sticky.sv
// Sticky event flags, cleared by writing ones.
// Assumes clear strobe and data come from one register write.
`timescale 1ns/100ps
module ccrc_sticky #(
	parameter int W = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] set,
	input wire logic clr_wr,
	input wire logic [W-1:0] clr_data,
	output logic [W-1:0] q
);
	logic [W-1:0] clr_mask;

	assign clr_mask = clr_wr ? clr_data : '0;

	// Set wins over a clear in the same cycle, so no event is lost
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= (q & ~clr_mask) | set;
		end
	end
endmodule // ccrc_sticky

// File: rtl/ccrc_top.sv
// Configurable CRC engine with APB registers and a scanner word port.
// Assumes one clock, APB master, scanner in the same clock domain.
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/100ps
module ccrc_top
	import ccrc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ccrc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scan_valid,
	input wire logic [15:0] scan_data,
	output logic scan_ready,
	output logic irq
);
	import ccrc_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	// Software settings and engine state, all held in flops
	ccrc_cfg_t cfg;
	ccrc_state_t state;
	logic [15:0] acc;
	logic [15:0] taps;
	logic [7:0] data_hi;
	logic [15:0] stage;
	logic [3:0] word_len;
	logic [3:0] bit_cnt;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_stat;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic setup;
	logic access;
	logic wr;
	logic lane0;
	logic wr_ctrl;
	logic wr_len;
	logic wr_dat_lo;
	logic wr_dat_hi;
	logic wr_acc;
	logic wr_taps;
	logic wr_stat;
	logic wr_mask;
	logic mapped;

	// Zero-wait slave: pready rises in the access cycle, from a flop
	assign setup = psel & ~penable;
	assign access = psel & penable & pready;
	assign wr = access & pwrite;
	// Byte registers need lane 0; wide ones take the word whole, so a
	// partial-strobe write to them still lands in full
	assign lane0 = pstrb[0];
	assign wr_ctrl = wr & lane0 & (paddr == OFF_CTRL);
	assign wr_len = wr & lane0 & (paddr == OFF_LEN);
	assign wr_dat_lo = wr & lane0 & (paddr == OFF_DAT_LO);
	assign wr_dat_hi = wr & lane0 & (paddr == OFF_DAT_HI);
	assign wr_acc = wr & (paddr == OFF_ACC);
	assign wr_taps = wr & (paddr == OFF_TAPS);
	assign wr_stat = wr & lane0 & (paddr == OFF_IRQ_STAT);
	assign wr_mask = wr & lane0 & (paddr == OFF_IRQ_MASK);
	assign mapped = (paddr == OFF_CTRL) | (paddr == OFF_LEN) |
		(paddr == OFF_DAT_LO) | (paddr == OFF_DAT_HI) |
		(paddr == OFF_ACC) | (paddr == OFF_TAPS) |
		(paddr == OFF_IRQ_STAT) | (paddr == OFF_IRQ_MASK);

	// ----------------------------------------------------------------
	// Word sources
	// ----------------------------------------------------------------
	logic scan_take;
	logic cpu_take;
	logic cpu_refused;
	logic load;
	logic [15:0] load_word;

	// Scanner wins a tie: its ready was already promised a cycle ago
	assign scan_take = scan_valid & scan_ready;
	// Low-byte write launches the word; high byte must come first
	assign cpu_take = wr_dat_lo & (state == ST_EMPTY) & ~scan_take;
	// A write while the stage is full is dropped and flagged
	assign cpu_refused = wr_dat_lo & ~cpu_take;
	// CPU word joins the held high byte with the low byte being written
	assign load = scan_take | cpu_take;
	assign load_word = scan_take ? scan_data : {data_hi, pwdata[7:0]};

	// ----------------------------------------------------------------
	// Shift engine datapath
	// ----------------------------------------------------------------
	logic step;
	logic last_bit;
	logic [3:0] msb_idx;
	logic [3:0] bit_idx;
	logic din;
	logic [15:0] taps_eff;
	logic [15:0] step_acc;

	// One data bit per clock, and only while go is set
	assign step = (state == ST_FULL) & cfg.go;
	assign last_bit = (bit_cnt == word_len);
	// Bits above the word length are never indexed
	assign msb_idx = word_len - bit_cnt;
	assign bit_idx = cfg.lsb_first ? bit_cnt : msb_idx;
	// Order bit is read live, so flipping it mid-word reorders the rest
	assign din = stage[bit_idx];
	// The lowest term is forced here, not stored in the register
	assign taps_eff = {taps[15:1], 1'b1};

	ccrc_bit_step u_step (
		.acc(acc),
		.taps(taps_eff),
		.poly_len(cfg.poly_len),
		.augment(cfg.augment),
		.din(din),
		.next_acc(step_acc)
	);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	ccrc_state_t next_state;
	logic next_go;
	logic done_evt;

	// Stage fills on a load, empties after the last bit of the word
	always_comb begin
		next_state = state;
		case (state)
			ST_EMPTY: begin
				if (load) begin
					next_state = ST_FULL;
				end
			end
			ST_FULL: begin
				if (step && last_bit) begin
					next_state = ST_EMPTY;
				end
			end
			default: begin
				next_state = ST_EMPTY;
			end
		endcase
	end

	// Go as it will be after this edge; the scanner ready looks ahead
	assign next_go = wr_ctrl ? pwdata[CTRL_GO_BIT] : cfg.go;
	// Busy falls exactly when the final bit of a word is shifted
	assign done_evt = (state == ST_FULL) & (next_state == ST_EMPTY);

	// ----------------------------------------------------------------
	// Engine registers
	// ----------------------------------------------------------------
	// Stage, counter and latched length for the word in flight
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ST_EMPTY;
			stage <= RST_STAGE;
			word_len <= RST_LEN_FIELD;
			bit_cnt <= RST_LEN_FIELD;
		end else begin
			state <= next_state;
			if (load && state == ST_EMPTY) begin
				stage <= load_word;
				word_len <= cfg.data_len;
				bit_cnt <= 4'h0;
			end else if (step) begin
				bit_cnt <= bit_cnt + 4'h1;
			end
		end
	end

	// Seed write wins over a shift: software owns the seed moment
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc <= RST_ACC;
		end else if (wr_acc) begin
			acc <= pwdata[15:0];
		end else if (step) begin
			acc <= step_acc;
		end
	end

	// Scanner may hand a word next cycle only into an empty stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scan_ready <= 1'b0;
		end else begin
			scan_ready <= next_go & (next_state == ST_EMPTY) & ~load;
		end
	end

	// ----------------------------------------------------------------
	// Software-written registers
	// ----------------------------------------------------------------
	// Configuration; changing the polynomial length mid-word affects the word in flight, the data length is latched at load
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg <= '0;
		end else begin
			cfg.go <= next_go;
			if (wr_ctrl) begin
				cfg.augment <= pwdata[CTRL_AUG_BIT];
				cfg.lsb_first <= pwdata[CTRL_ORDER_BIT];
			end
			if (wr_len) begin
				cfg.data_len <= pwdata[LEN_DATA_LENGTH_FIELD_LSB +: FIELD_W];
				cfg.poly_len <= pwdata[LEN_POLY_LENGTH_FIELD_LSB +: FIELD_W];
			end
		end
	end

	// Taps keep bit 0 at zero so it reads back as zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			taps <= RST_TAPS;
			data_hi <= RST_DATA_HI;
			irq_mask <= RST_IRQ_MASK;
		end else begin
			if (wr_taps) begin
				taps <= {pwdata[15:1], 1'b0};
			end
			if (wr_dat_hi) begin
				data_hi <= pwdata[7:0];
			end
			if (wr_mask) begin
				irq_mask <= pwdata[IRQ_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status
	// ----------------------------------------------------------------
	logic [IRQ_W-1:0] irq_set;

	// Events placed by the status layout, not by their order here
	always_comb begin
		irq_set = '0;
		irq_set[IRQ_DONE_BIT] = done_evt;
		irq_set[IRQ_OVR_BIT] = cpu_refused;
	end

	// Done flag sets regardless of mask; cleared only by a one write
	ccrc_sticky #(
		.W(IRQ_W)
	) u_flags (
		.clk(clk),
		.rst(rst),
		.set(irq_set),
		.clr_wr(wr_stat),
		.clr_data(pwdata[IRQ_W-1:0]),
		.q(irq_stat)
	);

	// Level output, one cycle behind the flag so it leaves a flop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic [31:0] ctrl_rd;
	logic [31:0] len_rd;
	logic [31:0] rd_mux;

	// Busy and full are one state bit; both kept for software that
	// polls either name
	always_comb begin
		ctrl_rd = 32'h0000_0000;
		ctrl_rd[CTRL_GO_BIT] = cfg.go;
		ctrl_rd[CTRL_AUG_BIT] = cfg.augment;
		ctrl_rd[CTRL_ORDER_BIT] = cfg.lsb_first;
		ctrl_rd[CTRL_BUSY_BIT] = (state == ST_FULL);
		ctrl_rd[CTRL_FULL_BIT] = (state == ST_FULL);
	end

	// Length fields read back as written, in their register positions
	assign len_rd = {24'h00_0000, cfg.poly_len, cfg.data_len};

	// High data register reads back what was written, low reads the staged word; unmapped reads zero
	always_comb begin
		case (paddr)
			OFF_CTRL: rd_mux = ctrl_rd;
			OFF_LEN: rd_mux = len_rd;
			OFF_DAT_LO: rd_mux = {16'h0000, stage};
			OFF_DAT_HI: rd_mux = {24'h00_0000, data_hi};
			OFF_ACC: rd_mux = {16'h0000, acc};
			OFF_TAPS: rd_mux = {16'h0000, taps};
			OFF_IRQ_STAT: rd_mux = {30'h0000_0000, irq_stat};
			OFF_IRQ_MASK: rd_mux = {30'h0000_0000, irq_mask};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// APB answer
	// ----------------------------------------------------------------
	// Answer sampled during setup, so the access ends in its first cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			prdata <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end
endmodule // ccrc_top

// File: testbench/ccrc_top_asserts.sv
// Port checker for the CRC engine, bound into ccrc_top.
// Assumes the APB master holds each request until pready.
`timescale 1ns/100ps
module ccrc_top_asserts
	import ccrc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ccrc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scan_valid,
	input wire logic [15:0] scan_data,
	input wire logic scan_ready,
	input wire logic irq
);
	// Completed reads, writes and scanner takes
	wire logic rd = pready && !pwrite;
	wire logic wr = psel && penable && pready && pwrite;
	wire logic take = scan_valid && scan_ready;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_ready_next: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_idle_zero: assert property (!pready |-> prdata == 32'h0 && !pslverr)
		else $error("read bus not quiet");
	a_bad_addr: assert property (rd && paddr > OFF_IRQ_MASK |->
		pslverr && prdata == 32'h0) else $error("unmapped not refused");
	a_taps_lsb: assert property (rd && paddr == OFF_TAPS |-> !prdata[0])
		else $error("taps bit zero reads one");
	a_acc_width: assert property (rd && paddr == OFF_ACC |->
		prdata[31:16] == 16'h0) else $error("accumulator upper bits");
	a_busy_full: assert property (rd && paddr == OFF_CTRL |->
		prdata[CTRL_BUSY_BIT] == prdata[CTRL_FULL_BIT] &&
		!($past(scan_ready) && prdata[CTRL_FULL_BIT]))
		else $error("busy and full disagree");
	a_take_drop: assert property (take |=> !scan_ready)
		else $error("ready stays after take");
	a_stop_go: assert property (wr && paddr == OFF_CTRL &&
		!pwdata[CTRL_GO_BIT] |=> ##1 !scan_ready)
		else $error("ready without go");
	a_mask_off: assert property (wr && paddr == OFF_IRQ_MASK &&
		pwdata[1:0] == 2'h0 |=> ##1 !irq) else $error("masked irq high");
	c_take: cover property (take);
	c_irq: cover property ($rose(irq));
	c_slverr: cover property (pready && pslverr);
endmodule // ccrc_top_asserts

bind ccrc_top ccrc_top_asserts u_ccrc_top_asserts (
	.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.scan_valid(scan_valid), .scan_data(scan_data),
	.scan_ready(scan_ready), .irq(irq));

// File: testbench/ccrc_scan_model.sv
// Program memory scanner model feeding words to the engine.
// Assumes the same clock as the engine; no reset of its own.
`timescale 1ns/100ps
module ccrc_scan_model (
	input wire logic clk,
	input wire logic scan_ready,
	output logic scan_valid,
	output logic [15:0] scan_data
);
	logic [15:0] word = 16'h0000;
	logic [15:0] noise = 16'h0000;
	initial scan_valid = 1'b0;
	// Idle data changes each cycle so stale words never look valid
	always @(posedge clk) noise <= noise + 16'h1357;
	assign scan_data = scan_valid ? word : noise;
	// Offer one word, hold it until taken
	task automatic send(input logic [15:0] w, input int gap);
		repeat (gap) @(posedge clk);
		@(posedge clk);
		word <= w;
		scan_valid <= 1'b1;
		do @(posedge clk); while (scan_ready !== 1'b1);
		scan_valid <= 1'b0;
	endtask
endmodule // ccrc_scan_model

// File: testbench/ccrc_top_tb_top.sv
// Self-checking bench: APB register tests and scanner words.
// Assumes ccrc_top, the scanner model and the bound checker.
`timescale 1ns/100ps
module ccrc_top_tb_top;
	import ccrc_pkg::*;
	localparam logic [15:0] TP = 16'h0006;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, scan_valid, scan_ready, irq, rerr;
	logic [15:0] scan_data, acc_exp, hi;
	logic [7:0] offs [6] = '{OFF_CTRL, OFF_LEN, OFF_ACC, OFF_TAPS,
		OFF_IRQ_STAT, OFF_IRQ_MASK};
	logic [15:0] ex [4] = '{16'h0055, 16'h0066, 16'h0077, 16'h0088};
	logic [15:0] wd [4] = '{16'hF3C5, 16'h9A0F, 16'h5E71, 16'hC0B8};
	int n_mismatch = 0;
	int compares = 0;
	always #2 clk = ~clk;
	ccrc_top u_ccrc_top (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scan_valid(scan_valid),
		.scan_data(scan_data), .scan_ready(scan_ready), .irq(irq));
	ccrc_scan_model u_ccrc_scan_model (.clk(clk),
		.scan_ready(scan_ready), .scan_valid(scan_valid),
		.scan_data(scan_data));
	// One APB transfer; no wait-state count is assumed
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic check(input logic [31:0] got, exp, input string m);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
		input string m);
		apb(1'b0, a, 32'h0);
		check(rdat, e, m);
	endtask
	// Polling busy; the watchdog bounds a stuck engine
	task automatic wait_free();
		do apb(1'b0, OFF_CTRL, 32'h0); while (rdat[CTRL_BUSY_BIT] !== 1'b0);
	endtask
	task automatic cpu_word(input logic [15:0] w);
		wait_free();
		wr(OFF_DAT_HI, {24'h0, w[15:8]});
		wr(OFF_DAT_LO, {24'h0, w[7:0]});
		hi = {8'h00, w[15:8]};
	endtask
	// Bitwise remainder model, direct form when augmenting
	function automatic logic [15:0] crc(input logic [15:0] a, t,
		input int pl, dl, input bit aug, lsb, input logic [15:0] w);
		logic b, fb;
		for (int i = 0; i <= dl; i++) begin
			b = lsb ? w[i] : w[dl - i];
			fb = a[pl] ^ (aug & b);
			a = {a[14:0], ~aug & b};
			if (fb) a = a ^ (t | 16'h0001);
			a = a & 16'((17'h1 << (pl + 1)) - 1);
		end
		return a;
	endfunction
	task automatic finish_test();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Watchdog, well beyond the expected run
	initial begin
		#200000;
		n_mismatch++;
		finish_test();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		foreach (offs[i]) rd_chk(offs[i], 32'h0, "reset");
		rd_chk(8'h20, 32'h0, "unmapped");
		check({31'h0, rerr}, 32'h1, "slverr");
		wr(OFF_TAPS, 32'h8005);
		rd_chk(OFF_TAPS, 32'h8004, "taps");
		wr(OFF_LEN, 32'hF7);
		wr(OFF_IRQ_MASK, 32'h1);
		// Known answers, MSb first then LSb first, augmented
		for (int m = 0; m < 2; m++) begin
			wr(OFF_ACC, 32'h0);
			wr(OFF_CTRL, m ? 32'h7 : 32'h3);
			foreach (ex[i]) cpu_word(ex[i]);
			wait_free();
			rd_chk(OFF_ACC, m ? 32'h6BA2 : 32'h32D6, "known");
			rd_chk(OFF_IRQ_STAT, 32'h1, "done");
			check({31'h0, irq}, 32'h1, "irq on");
			wr(OFF_IRQ_STAT, 32'h3);
			rd_chk(OFF_IRQ_STAT, 32'h0, "w1c");
			check({31'h0, irq}, 32'h0, "irq off");
		end
		// 8-bit remainder, 12-bit words, seeded, both sources
		wr(OFF_TAPS, {16'h0, TP});
		wr(OFF_LEN, 32'h7B);
		wr(OFF_ACC, 32'hA5);
		wr(OFF_CTRL, 32'h1);
		acc_exp = 16'h00A5;
		foreach (wd[i]) begin
			if (i % 2 == 0) cpu_word(wd[i]);
			else u_ccrc_scan_model.send(wd[i], 3);
			acc_exp = crc(acc_exp, TP, 7, 11, 1'b0, 1'b0, wd[i]);
		end
		wait_free();
		rd_chk(OFF_ACC, {16'h0, acc_exp}, "narrow");
		// Low byte written while the stage is still full
		wr(OFF_IRQ_STAT, 32'h3);
		wr(OFF_LEN, 32'hFF);
		wr(OFF_ACC, 32'h0);
		wr(OFF_DAT_LO, 32'h3C);
		wr(OFF_DAT_LO, 32'hC3);
		wait_free();
		acc_exp = crc(16'h0, TP, 15, 15, 1'b0, 1'b0, {hi[7:0], 8'h3C});
		rd_chk(OFF_ACC, {16'h0, acc_exp}, "refused");
		rd_chk(OFF_IRQ_STAT, 32'h3, "ovr flag");
		// Clearing go pauses a pending word
		wr(OFF_CTRL, 32'h0);
		wr(OFF_ACC, 32'h0);
		wr(OFF_DAT_LO, 32'h01);
		repeat (20) @(posedge clk);
		check({31'h0, scan_ready}, 32'h0, "no take");
		rd_chk(OFF_ACC, 32'h0, "paused");
		rd_chk(OFF_CTRL, 32'h30, "pending");
		wr(OFF_CTRL, 32'h1);
		wait_free();
		acc_exp = crc(16'h0, TP, 15, 15, 1'b0, 1'b0, {hi[7:0], 8'h01});
		rd_chk(OFF_ACC, {16'h0, acc_exp}, "resume");
		// Masking hides a pending done flag; the refused bit still stands
		wr(OFF_IRQ_MASK, 32'h0);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h0, "masked");
		rd_chk(OFF_IRQ_STAT, 32'h3, "still set");
		finish_test();
	end
endmodule // ccrc_top_tb_top
